/* core/svrs_top.sv */
// Vector register state: vector and packed-integer files, control/status,
// compare flags, save/restore walker and APB register slave.
// Assumes decode drives requests on sys_clk; APB on the same clock.
`timescale 1ns/1ps
`default_nettype none

module svrs_top
    import svrs_pkg::*;
#(
    parameter int NUM_VEC = svrs_pkg::VEC_NUM_WIDE
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // Decode side
    input wire svrs_pkg::svrs_prefix_type prefix,
    input wire logic prefix_meaningful,
    input wire logic [VIDX_W-2:0] vec_rd_idx,
    input wire svrs_pkg::svrs_vwr_type vec_wr,
    input wire logic [PIDX_W-1:0] pi_rd_idx,
    input wire svrs_pkg::svrs_pwr_type pi_wr,
    input wire logic cmp_wr,
    input wire logic [FLAG_W-1:0] cmp_flags,
    input wire logic save_req,
    input wire logic restore_req,
    input wire logic [CSR_W-1:0] restore_csr,
    input wire logic [VEC_W-1:0] restore_vec,
    // Results
    output logic [VEC_W-1:0] vec_rd_data,
    output logic [PI_W-1:0] pi_rd_data,
    output logic [FLAG_W-1:0] flags_out,
    output logic [CSR_W-1:0] csr_out,
    output logic daz_out,
    output logic gpr_wide_out,
    output logic sr_busy,
    output logic save_valid,
    output logic [VIDX_W-1:0] save_idx,
    output logic [VEC_W-1:0] save_vec,
    output logic gp_fault
);
    import svrs_pkg::*;

    logic [VEC_W-1:0] vec_r [NUM_VEC];
    logic [PI_W-1:0] pi_r [PI_NUM];
    logic [CSR_W-1:0] csr_r;
    logic [EV_W-1:0] status_r, mask_r;
    svrs_mode_type mode_r;
    svrs_sr_type sr_r;
    logic [VIDX_W-1:0] sr_idx_r;
    logic [VIDX_W-1:0] sr_last;
    logic [EV_W-1:0] ev_set;
    logic long_mode;
    logic ext_ok;
    logic [VIDX_W-1:0] rd_full;
    logic [VIDX_W-1:0] wr_full;
    logic apb_wr, apb_rd;

    // Extension bit only honoured in long mode
    function automatic logic [VIDX_W-1:0] vidx(
        input logic [VIDX_W-1:0] raw,
        input logic ok
    );
        vidx = {raw[VIDX_W-1] & ok, raw[VIDX_W-2:0]};
    endfunction

    assign long_mode = (mode_r == SVRS_MODE_LONG);
    // Protected, real and v86 share one path
    assign ext_ok = long_mode && prefix.present && prefix_meaningful;
    assign rd_full = vidx({prefix.reg_ext, vec_rd_idx}, ext_ok);
    assign wr_full = vidx(vec_wr.idx, long_mode);
    assign sr_last = long_mode ? 4'(VEC_NUM_WIDE - 1) : 4'(VEC_NUM_LEGACY - 1);
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;

    // Vector file, one shared state for both instruction sets
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_VEC; i++) begin
                vec_r[i] <= '0;
            end
        end else if (sr_r == SVRS_SR_REST && !gp_fault) begin
            vec_r[sr_idx_r] <= restore_vec;
        end else if (vec_wr.en) begin
            if (vec_wr.scalar) begin
                // Upper quadword passes through
                vec_r[wr_full][QW_W-1:0] <=
                    vec_wr.data[QW_W-1:0];
            end else begin
                vec_r[wr_full] <= vec_wr.data;
            end
        end
    end

    // Packed-integer file, independent storage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PI_NUM; i++) begin
                pi_r[i] <= '0;
            end
        end else if (pi_wr.en) begin
            pi_r[pi_wr.idx] <= pi_wr.data;
        end
    end

    // Read ports; addresses never come from these files
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_rd_data <= '0;
            pi_rd_data <= '0;
            gpr_wide_out <= 1'b0;
        end else begin
            vec_rd_data <= vec_r[rd_full];
            pi_rd_data <= pi_r[pi_rd_idx];
            gpr_wide_out <= ext_ok && prefix.width_bit;
        end
    end

    // Compare results into the flags word
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_out <= '0;
        end else if (cmp_wr) begin
            flags_out <= cmp_flags;
        end
    end

    // Save/restore walker, one beat per vector entry: 16 in long mode, 8 in other modes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sr_r <= SVRS_SR_IDLE;
            sr_idx_r <= '0;
        end else begin
            case (sr_r)
                SVRS_SR_IDLE: begin
                    sr_idx_r <= '0;
                    if (save_req) begin
                        sr_r <= SVRS_SR_SAVE;
                    end else if (restore_req &&
                            (restore_csr & ~CSR_VALID_MASK) == '0) begin
                        sr_r <= SVRS_SR_REST;
                    end
                end
                SVRS_SR_SAVE, SVRS_SR_REST: begin
                    sr_idx_r <= sr_idx_r + 4'h1;
                    if (sr_idx_r == sr_last) begin
                        sr_r <= SVRS_SR_IDLE;
                    end
                end
                default: sr_r <= SVRS_SR_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            save_valid <= 1'b0;
            save_idx <= '0;
            save_vec <= '0;
            sr_busy <= 1'b0;
            gp_fault <= 1'b0;
        end else begin
            save_valid <= (sr_r == SVRS_SR_SAVE);
            save_idx <= sr_idx_r;
            save_vec <= vec_r[sr_idx_r];
            sr_busy <= (sr_r != SVRS_SR_IDLE) || save_req || restore_req;
            // Reserved bits set in restored value
            gp_fault <= (sr_r == SVRS_SR_IDLE) && !save_req && restore_req &&
                ((restore_csr & ~CSR_VALID_MASK) != '0);
        end
    end

    // Control/status: restore or APB write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            csr_r <= CSR_RESET;
        end else if (sr_r == SVRS_SR_IDLE && !save_req && restore_req &&
                (restore_csr & ~CSR_VALID_MASK) == '0) begin
            csr_r <= restore_csr;
        end else if (apb_wr && paddr == ADDR_CSR) begin
            csr_r <= pwdata & CSR_VALID_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            csr_out <= CSR_RESET;
            daz_out <= CSR_RESET[CSR_DAZ_BIT];
        end else begin
            csr_out <= csr_r;
            daz_out <= csr_r[CSR_DAZ_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= SVRS_MODE_PROT;
        end else if (apb_wr && paddr == ADDR_MODE) begin
            mode_r <= svrs_mode_type'(pwdata[MODE_W-1:0]);
        end
    end

    // Sticky events, set wins over write-one-to-clear
    always_comb begin
        ev_set = '0;
        ev_set[EV_GPF] = gp_fault;
        ev_set[EV_SAVE] = sr_r == SVRS_SR_SAVE && sr_idx_r == sr_last;
        ev_set[EV_RESTORE] = sr_r == SVRS_SR_REST && sr_idx_r == sr_last;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= '0;
            mask_r <= '0;
        end else begin
            if (apb_wr && paddr == ADDR_STATUS) begin
                status_r <= (status_r & ~pwdata[EV_W-1:0]) | ev_set;
            end else begin
                status_r <= status_r | ev_set;
            end
            if (apb_wr && paddr == ADDR_MASK) begin
                mask_r <= pwdata[EV_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_r & mask_r);
        end
    end

    // APB: data registered in setup, ready in access phase
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == ADDR_CSR ||
                paddr == ADDR_STATUS || paddr == ADDR_MASK ||
                paddr == ADDR_MODE || paddr == ADDR_IDRES);
            if (apb_rd) begin
                case (paddr)
                    ADDR_CSR: prdata <= csr_r;
                    ADDR_STATUS: prdata <= {29'h0, status_r};
                    ADDR_MASK: prdata <= {29'h0, mask_r};
                    ADDR_MODE: prdata <= {30'h0, mode_r};
                    // Feature present in identification word
                    ADDR_IDRES: prdata <= 32'h1 << ID_FEATURE_BIT;
                    default: prdata <= '0;
                endcase
            end
        end
    end

    // Assertions
    property p_daz;
        @(posedge sys_clk) disable iff (!rst_n)
        1'b1 |=> daz_out == $past(csr_r[CSR_DAZ_BIT]);
    endproperty
    daz_follows_csr_a: assert property (p_daz)
        else $error("daz output mismatch");

    high_regs_guard_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !long_mode |-> !rd_full[VIDX_W-1])
        else $error("extended register reached outside long mode");

    legacy_guard_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!long_mode && sr_r != SVRS_SR_REST && vec_wr.en) |=>
        vec_r[$past({1'b1, vec_wr.idx[VIDX_W-2:0]})] ==
            $past(vec_r[{1'b1, vec_wr.idx[VIDX_W-2:0]}]))
        else $error("upper vector entry written outside long mode");

    wide_gpr_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (long_mode && prefix.present && prefix_meaningful &&
         prefix.width_bit) |=> gpr_wide_out)
        else $error("width bit not honoured");

    ignored_prefix_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !prefix_meaningful |=> !gpr_wide_out)
        else $error("meaningless prefix had effect");

    flags_write_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cmp_wr |=> flags_out == $past(cmp_flags))
        else $error("compare flags not written");

    scalar_upper_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (sr_r == SVRS_SR_IDLE && vec_wr.en && vec_wr.scalar) |=>
        vec_r[$past(wr_full)] == {$past(vec_r[wr_full][VEC_W-1:QW_W]),
            $past(vec_wr.data[QW_W-1:0])})
        else $error("scalar write disturbed upper quadword");

    sequence s_bad_restore;
        sr_r == SVRS_SR_IDLE && !save_req && restore_req &&
            (restore_csr & ~CSR_VALID_MASK) != '0;
    endsequence
    restore_fault_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        s_bad_restore |=> gp_fault && $stable(csr_r))
        else $error("reserved csr bits not faulted");

    sequence s_good_restore;
        sr_r == SVRS_SR_IDLE && !save_req && restore_req &&
            (restore_csr & ~CSR_VALID_MASK) == '0;
    endsequence
    restore_load_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        s_good_restore |=> csr_r == $past(restore_csr) &&
            sr_r == SVRS_SR_REST && !gp_fault)
        else $error("valid restore not loaded");

    csr_reserved_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (csr_r & ~CSR_VALID_MASK) == '0)
        else $error("reserved csr bits set");

    id_read_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (apb_rd && paddr == ADDR_IDRES) |=> prdata[ID_FEATURE_BIT])
        else $error("feature bit not reported");

    sequence s_save_start;
        sr_r == SVRS_SR_IDLE && save_req;
    endsequence
    save_walk_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        s_save_start ##1 !long_mode |-> ##1 save_valid [*8] ##1 !save_valid)
        else $error("save walk length wrong");

    save_busy_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        save_valid |-> sr_busy)
        else $error("busy low during save beat");

    apb_ready_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (psel && !penable) |=> pready)
        else $error("no ready in access phase");

    irq_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        1'b1 |=> irq == $past(|(status_r & mask_r)))
        else $error("interrupt level mismatch");
endmodule
`default_nettype wire

/* core/svrs_pkg.sv */
// Shared constants and carriers for the vector register state block.
// Assumes a single core clock and an APB master for software access.
package svrs_pkg;
    localparam int VEC_W = 128;
    localparam int QW_W = 64;
    localparam int PI_W = 64;
    localparam int CSR_W = 32;
    localparam int VEC_NUM_LEGACY = 8;
    localparam int VEC_NUM_WIDE = 16;
    localparam int PI_NUM = 8;
    localparam int VIDX_W = 4;
    localparam int PIDX_W = 3;
    localparam int FLAG_W = 32;
    // Feature bit inside the identification result word
    localparam int ID_FEATURE_BIT = 26;
    localparam logic [31:0] ID_LEAF_FEATURES = 32'h0000_0001;
    // Control/status layout
    localparam int CSR_DAZ_BIT = 6;
    localparam logic [31:0] CSR_RESET = 32'h0000_1f80;
    localparam logic [31:0] CSR_VALID_MASK = 32'h0000_ffff;
    // Register map, byte addresses
    localparam logic [11:0] ADDR_CSR = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_MASK = 12'h008;
    localparam logic [11:0] ADDR_MODE = 12'h00c;
    localparam logic [11:0] ADDR_IDRES = 12'h010;
    // Event bits in status and mask
    localparam int EV_W = 3;
    localparam int EV_GPF = 0;
    localparam int EV_SAVE = 1;
    localparam int EV_RESTORE = 2;
    localparam int MODE_W = 2;

    typedef enum logic [1:0] {
        SVRS_MODE_PROT = 2'b00,
        SVRS_MODE_REAL = 2'b01,
        SVRS_MODE_V86 = 2'b11,
        SVRS_MODE_LONG = 2'b10
    } svrs_mode_type;

    // Decoded register-extension prefix
    typedef struct packed {
        logic present;
        logic width_bit;
        logic reg_ext;
    } svrs_prefix_type;

    // Vector write port
    typedef struct packed {
        logic en;
        logic scalar;
        logic [VIDX_W-1:0] idx;
        logic [VEC_W-1:0] data;
    } svrs_vwr_type;

    // Packed-integer write port
    typedef struct packed {
        logic en;
        logic [PIDX_W-1:0] idx;
        logic [PI_W-1:0] data;
    } svrs_pwr_type;

    // Save/restore step: one beat per vector entry (16 in long mode, 8 otherwise), csr loaded at request
    typedef enum logic [1:0] {
        SVRS_SR_IDLE = 2'b00,
        SVRS_SR_SAVE = 2'b01,
        SVRS_SR_REST = 2'b11
    } svrs_sr_type;
endpackage

/* verif/svrs_dec_model.sv */
// Decode-side partner: supplies one restore vector per beat.
// Assumes the sys_clk domain and the active-low async reset.
`timescale 1ns/1ps
`default_nettype none
module svrs_dec_model
    import svrs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic restore_req,
    input wire logic wide,
    output logic [VEC_W-1:0] restore_vec
);
    logic act_r;
    logic [4:0] beat_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            act_r <= 1'h0;
            beat_r <= 5'h00;
            restore_vec <= '0;
        end else if (restore_req && !act_r) begin
            act_r <= 1'h1;
            beat_r <= 5'h00;
            restore_vec <= {4{28'h5a5a5a5, 4'h0}};
        end else if (act_r && beat_r < (wide ? 5'h0f : 5'h07)) begin
            beat_r <= beat_r + 5'h01;
            restore_vec <= {4{28'h5a5a5a5, beat_r[3:0] + 4'h1}};
        end else begin
            // Off-beat data keeps toggling
            act_r <= 1'h0;
            restore_vec <= ~restore_vec;
        end
    end
endmodule
`default_nettype wire

/* verif/svrs_top_tb.sv */
// Self-checking bench for the vector register state block.
// Assumes the package, the design and the partner model come first.
`timescale 1ns/1ps
`default_nettype none
module svrs_top_tb;
    import svrs_pkg::*;
    typedef struct {logic [11:0] a; logic [31:0] e;} svrs_row_type;
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, flags_out, csr_out;
    logic pready, pslverr, irq, daz_out, gpr_wide_out, sr_busy;
    logic save_valid, gp_fault, wide = 1'h0;
    svrs_prefix_type prefix = '0;
    logic prefix_meaningful = 1'h0, cmp_wr = 1'h0;
    logic save_req = 1'h0, restore_req = 1'h0;
    logic [2:0] vec_rd_idx = 3'h0, pi_rd_idx = 3'h0;
    svrs_vwr_type vec_wr = '0;
    svrs_pwr_type pi_wr = '0;
    logic [31:0] cmp_flags = 32'h0, restore_csr = 32'h0;
    logic [127:0] restore_vec, vec_rd_data, save_vec;
    logic [63:0] pi_rd_data;
    logic [3:0] save_idx;
    logic [127:0] sh [16] = '{default: 128'h0};
    logic [1:0] mv [3] = '{2'h0, 2'h1, 2'h3};
    int bad_count = 0, total_checks = 0, n;
    svrs_row_type rows [6] = '{'{ADDR_CSR, CSR_RESET},
        '{ADDR_STATUS, 32'h0}, '{ADDR_MASK, 32'h0}, '{ADDR_MODE, 32'h0},
        '{ADDR_IDRES, 32'h1 << ID_FEATURE_BIT}, '{12'h020, 32'h0}};

    always #20 sys_clk = ~sys_clk;

    svrs_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .prefix(prefix),
        .prefix_meaningful(prefix_meaningful), .vec_rd_idx(vec_rd_idx),
        .vec_wr(vec_wr), .pi_rd_idx(pi_rd_idx), .pi_wr(pi_wr),
        .cmp_wr(cmp_wr), .cmp_flags(cmp_flags), .save_req(save_req),
        .restore_req(restore_req), .restore_csr(restore_csr),
        .restore_vec(restore_vec), .vec_rd_data(vec_rd_data),
        .pi_rd_data(pi_rd_data), .flags_out(flags_out),
        .csr_out(csr_out), .daz_out(daz_out),
        .gpr_wide_out(gpr_wide_out), .sr_busy(sr_busy),
        .save_valid(save_valid), .save_idx(save_idx),
        .save_vec(save_vec), .gp_fault(gp_fault));
    svrs_dec_model partner (.sys_clk(sys_clk), .rst_n(rst_n),
        .restore_req(restore_req), .wide(wide),
        .restore_vec(restore_vec));

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic md(input logic [1:0] m);
        apb(1'h1, ADDR_MODE, {30'h0, m});
        wide <= (m == 2'h2);
        cyc(1);
    endtask
    task automatic wv(input logic [3:0] i, input logic s,
            input logic [127:0] d);
        logic [3:0] j;
        j = wide ? i : {1'h0, i[2:0]};
        @(posedge sys_clk);
        vec_wr <= '{en: 1'h1, scalar: s, idx: i, data: d};
        @(posedge sys_clk);
        vec_wr.en <= 1'h0;
        sh[j] = s ? {sh[j][127:64], d[63:0]} : d;
    endtask
    task automatic rv(input logic [3:0] i);
        @(posedge sys_clk);
        vec_rd_idx <= i[2:0];
        prefix <= '{present: i[3], width_bit: 1'h0, reg_ext: i[3]};
        prefix_meaningful <= 1'h1;
        cyc(2);
        chk(vec_rd_data, sh[wide ? i : {1'h0, i[2:0]}]);
    endtask
    task automatic rst_req(input logic [31:0] c);
        @(posedge sys_clk);
        restore_csr <= c;
        restore_req <= 1'h1;
        @(posedge sys_clk);
        restore_req <= 1'h0;
    endtask
    task automatic sv(input logic [5:0] cnt);
        @(posedge sys_clk);
        save_req <= 1'h1;
        @(posedge sys_clk);
        save_req <= 1'h0;
        n = 0;
        repeat (40) begin
            @(posedge sys_clk);
            if (save_valid === 1'h1) begin
                chk(save_idx, n[3:0]);
                chk(save_vec, sh[n[3:0]]);
                chk(sr_busy, 1'h1);
                n++;
            end
        end
        chk(n[5:0], cnt);
        chk(sr_busy, 1'h0);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end

    initial begin
        cyc(4);
        rst_n <= 1'h1;
        foreach (rows[r]) begin
            apb(1'h0, rows[r].a, 32'h0);
            chk(rd & (r == 4 ? rows[r].e : '1), rows[r].e);
        end
        chk(er, 1'h1);
        $display("register reset test done");
        apb(1'h1, ADDR_CSR, 32'h0000_0040);
        cyc(2);
        chk(daz_out, 1'h1);
        chk(csr_out, 32'h0000_0040);
        apb(1'h1, ADDR_CSR, CSR_RESET);
        cyc(2);
        chk(daz_out, 1'h0);
        foreach (mv[q]) begin
            md(mv[q]);
            wv({1'h1, 3'(q + 1)}, 1'h0, {4{32'hbeef_0000 + q}});
            rv({1'h1, 3'(q + 1)});
        end
        wv(4'h0, 1'h1, {128{1'h1}});
        rv(4'h0);
        md(2'h2);
        wv(4'h9, 1'h0, {4{32'h1234_5678}});
        rv(4'h9);
        rv(4'h1);
        $display("vector file test done");
        @(posedge sys_clk);
        pi_wr <= '{en: 1'h1, idx: 3'h5, data: 64'hfeed_face_0bad_f00d};
        pi_rd_idx <= 3'h5;
        @(posedge sys_clk);
        pi_wr.en <= 1'h0;
        cyc(3);
        chk(pi_rd_data, 64'hfeed_face_0bad_f00d);
        rv(4'h5);
        @(posedge sys_clk);
        cmp_wr <= 1'h1;
        cmp_flags <= 32'h0000_0045;
        @(posedge sys_clk);
        cmp_wr <= 1'h0;
        cyc(2);
        chk(flags_out, 32'h0000_0045);
        for (int p = 0; p < 2; p++) begin
            @(posedge sys_clk);
            prefix <= '{present: 1'h1, width_bit: 1'h1, reg_ext: 1'h0};
            prefix_meaningful <= p[0];
            cyc(3);
            chk(gpr_wide_out, p[0]);
        end
        $display("operand test done");
        apb(1'h1, ADDR_MASK, 32'h0000_0007);
        sv(6'h10);
        chk(irq, 1'h1);
        apb(1'h1, ADDR_STATUS, 32'h0000_0007);
        cyc(2);
        chk(irq, 1'h0);
        rst_req(32'h0001_0000);
        n = 0;
        repeat (4) begin
            @(posedge sys_clk);
            if (gp_fault === 1'h1) n++;
        end
        chk(n[5:0], 6'h01);
        cyc(20);
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        chk(irq, 1'h1);
        chk(csr_out, CSR_RESET);
        apb(1'h1, ADDR_STATUS, 32'h0000_0007);
        $display("save and fault test done");
        md(2'h0);
        rst_req(32'h0000_1fc0);
        cyc(14);
        for (int i = 0; i < 8; i++) sh[i] = {4{28'h5a5a5a5, 4'(i)}};
        chk(csr_out, 32'h0000_1fc0);
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0000_0004);
        sv(6'h08);
        md(2'h2);
        for (int i = 0; i < 16; i++) rv(4'(i));
        $display("restore test done");
        print_verdict();
    end
endmodule
`default_nettype wire
